/* seo_enable_out_cfg.v */
// Supply-enable output configuration registers and per-channel output control
`timescale 1ns/1ps
`include "seo_defs.vh"

// Functional notes
// - Twelve enable outputs exist on the large variant and eight on the small one.
// - All output configuration lives in byte registers 1Fh through 22h, software writable.
// - Three-bit codes 000-011 pick open-drain or push-pull with low or high assertion.
// - Code 100 on channels one to four selects closed-loop tracking.
// - Code 101 on channels one to six selects charge-pump drive of an n-channel gate.
// - Code 100 on channels five and six is reserved and leaves the output idle.
// - Only channels 1-4 track, 1-6 pump, the rest have the four driver options only.
// - Channel 1 is 1Fh[2:0], channel 2 1Fh[5:3], channel 4 20h[3:1], channel 5 20h[6:4].
// - Channel 3 takes its low bits from 1Fh[7:6] and its top bit from 20h[0].
// - Channel 6 takes its low bit from 20h[7] and its top bits from 21h[1:0].
// - Channels 7-9 use two-bit fields at 21h[3:2], [5:4] and [7:6].
// - Channels 10-12 use two-bit fields at 22h[1:0], [3:2], [5:4]; 22h[7:6] is reserved.
// - An output asserts at the end of its slot once that slot's delay is done.
module seo_enable_out_cfg #(
    parameter NUM_CH = `SEO_CH_LARGE
) (
    input  wire                core_clk,
    input  wire                sys_rst,
    input  wire                cfg_wr_en,
    input  wire                cfg_rd_en,
    input  wire [7:0]          cfg_addr,
    input  wire [7:0]          cfg_wdata,
    input  wire [11:0]         slot_done,
    output reg  [7:0]          cfg_rdata_q,
    output reg  [11:0]         supply_enable_outputs_all_q,
    output reg  [11:0]         supply_enable_oe_n_q,
    output reg  [11:0]         charge_pump_on_q,
    output reg  [11:0]         track_on_q,
    output reg  [11:0]         cfg_reserved_q,
    output reg  [11:0]         asserted_q
);

    // ****************************************
    // Configuration registers
    // ****************************************
    reg  [7:0]  cfg_a_q;
    reg  [7:0]  cfg_b_q;
    reg  [7:0]  cfg_c_q;
    reg  [7:0]  cfg_d_q;
    reg  [11:0] req_q;
    reg  [7:0]  rdata_d;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_a_q <= `SEO_CFG_RST;
            cfg_b_q <= `SEO_CFG_RST;
            cfg_c_q <= `SEO_CFG_RST;
            cfg_d_q <= `SEO_CFG_RST;
        end else if (cfg_wr_en) begin
            if (cfg_addr == `SEO_OFF_CFG_A) begin
                cfg_a_q <= cfg_wdata;
            end else if (cfg_addr == `SEO_OFF_CFG_B) begin
                cfg_b_q <= cfg_wdata;
            end else if (cfg_addr == `SEO_OFF_CFG_C) begin
                cfg_c_q <= cfg_wdata;
            end else if (cfg_addr == `SEO_OFF_CFG_D) begin
                // reserved top bits held at zero
                cfg_d_q <= cfg_wdata & `SEO_CFG_D_MASK;
            end
        end
    end

    always @* begin
        rdata_d = 8'h00;
        if (cfg_addr == `SEO_OFF_CFG_A) begin
            rdata_d = cfg_a_q;
        end else if (cfg_addr == `SEO_OFF_CFG_B) begin
            rdata_d = cfg_b_q;
        end else if (cfg_addr == `SEO_OFF_CFG_C) begin
            rdata_d = cfg_c_q;
        end else if (cfg_addr == `SEO_OFF_CFG_D) begin
            rdata_d = cfg_d_q;
        end
    end

    // ****************************************
    // Field extraction
    // ****************************************
    wire [2:0] code [0:11];
    assign code[0]  = cfg_a_q[2:0];
    assign code[1]  = cfg_a_q[5:3];
    assign code[2]  = {cfg_b_q[0], cfg_a_q[7:6]};
    assign code[3]  = cfg_b_q[3:1];
    assign code[4]  = cfg_b_q[6:4];
    assign code[5]  = {cfg_c_q[1:0], cfg_b_q[7]};
    assign code[6]  = {1'b0, cfg_c_q[3:2]};
    assign code[7]  = {1'b0, cfg_c_q[5:4]};
    assign code[8]  = {1'b0, cfg_c_q[7:6]};
    assign code[9]  = {1'b0, cfg_d_q[1:0]};
    assign code[10] = {1'b0, cfg_d_q[3:2]};
    assign code[11] = {1'b0, cfg_d_q[5:4]};

    // ****************************************
    // Per-channel decode
    // ****************************************
    wire [11:0] pin_d;
    wire [11:0] oe_n_d;
    wire [11:0] pump_d;
    wire [11:0] track_d;
    wire [11:0] rsvd_d;

    genvar ch;
    generate
        for (ch = 0; ch < 12; ch = ch + 1) begin : g_ch
            wire [2:0] mode;
            seo_chan_decode #(
                .HAS_TRACK (ch < `SEO_CH_TRACK),
                .HAS_PUMP  (ch < `SEO_CH_PUMP),
                .PRESENT   ((NUM_CH >= `SEO_CH_LARGE) || (ch < `SEO_CH_SMALL))
            ) u_dec (
                .cfg_code    (code[ch]),
                .assert_req  (req_q[ch]),
                .mode        (mode),
                .pin_out     (pin_d[ch]),
                .pin_oe_n    (oe_n_d[ch]),
                .active_high (),
                .pump_on     (pump_d[ch]),
                .track_on    (track_d[ch])
            );
            assign rsvd_d[ch] = (mode == `SEO_MODE_RSVD);
        end
    endgenerate

    // channels beyond the variant never assert
    wire [11:0] present_mask = (NUM_CH >= 12) ? 12'hFFF : 12'h0FF;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_q                       <= 12'h000;
            cfg_rdata_q                 <= 8'h00;
            supply_enable_outputs_all_q <= 12'h000;
            supply_enable_oe_n_q        <= 12'hFFF;
            charge_pump_on_q            <= 12'h000;
            track_on_q                  <= 12'h000;
            cfg_reserved_q              <= 12'h000;
            asserted_q                  <= 12'h000;
        end else begin
            req_q                       <= slot_done & present_mask & ~rsvd_d;
            if (cfg_rd_en) begin
                cfg_rdata_q <= rdata_d;
            end
            supply_enable_outputs_all_q <= pin_d;
            supply_enable_oe_n_q        <= oe_n_d;
            charge_pump_on_q            <= pump_d;
            track_on_q                  <= track_d;
            cfg_reserved_q              <= rsvd_d & present_mask;
            asserted_q                  <= req_q;
        end
    end

endmodule

/* seo_defs.vh */
// Register offsets, channel counts, codes and modes of the supply-enable output configuration bank
`ifndef SEO_DEFS_VH
`define SEO_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define SEO_ADDR_W          8
`define SEO_OFF_CFG_A       8'h1F
`define SEO_OFF_CFG_B       8'h20
`define SEO_OFF_CFG_C       8'h21
`define SEO_OFF_CFG_D       8'h22
`define SEO_CFG_RST         8'h00
`define SEO_CFG_D_MASK      8'h3F

// ****************************************
// Channel counts
// ****************************************
`define SEO_CH_LARGE        12
`define SEO_CH_SMALL        8
`define SEO_CH_TRACK        4
`define SEO_CH_PUMP         6

// ****************************************
// Configuration codes
// ****************************************
`define SEO_CODE_OD_LOW     3'h0
`define SEO_CODE_OD_HIGH    3'h1
`define SEO_CODE_PP_LOW     3'h2
`define SEO_CODE_PP_HIGH    3'h3
`define SEO_CODE_TRACK      3'h4
`define SEO_CODE_PUMP       3'h5

// ****************************************
// Channel modes reported per channel
// ****************************************
`define SEO_MODE_W          3
`define SEO_MODE_OD         3'h0
`define SEO_MODE_PP         3'h1
`define SEO_MODE_TRACK      3'h2
`define SEO_MODE_PUMP       3'h3
`define SEO_MODE_RSVD       3'h4
`define SEO_MODE_ABSENT     3'h5

`endif

/* seo_chan_decode.v */
// Per-channel decode of a configuration code into driver mode and pin controls
`timescale 1ns/1ps
`include "seo_defs.vh"

module seo_chan_decode #(
    parameter HAS_TRACK = 0,
    parameter HAS_PUMP  = 0,
    parameter PRESENT   = 1
) (
    input  wire [2:0] cfg_code,
    input  wire       assert_req,
    output reg  [2:0] mode,
    output reg        pin_out,
    output reg        pin_oe_n,
    output reg        active_high,
    output reg        pump_on,
    output reg        track_on
);
    always @* begin
        mode        = `SEO_MODE_RSVD;
        pin_out     = 1'b0;
        pin_oe_n    = 1'b1;
        active_high = cfg_code[0];
        pump_on     = 1'b0;
        track_on    = 1'b0;
        if (PRESENT == 0) begin
            mode        = `SEO_MODE_ABSENT;
            active_high = 1'b0;
        end else begin
            case (cfg_code)
                `SEO_CODE_OD_LOW, `SEO_CODE_OD_HIGH: begin
                    mode     = `SEO_MODE_OD;
                    pin_out  = 1'b0;
                    pin_oe_n = ~(assert_req ^ cfg_code[0]);
                end
                `SEO_CODE_PP_LOW, `SEO_CODE_PP_HIGH: begin
                    mode     = `SEO_MODE_PP;
                    pin_out  = ~(assert_req ^ cfg_code[0]);
                    pin_oe_n = 1'b0;
                end
                `SEO_CODE_TRACK: begin
                    active_high = 1'b0;
                    if (HAS_TRACK != 0) begin
                        mode     = `SEO_MODE_TRACK;
                        track_on = assert_req;
                    end
                end
                `SEO_CODE_PUMP: begin
                    active_high = 1'b0;
                    if (HAS_PUMP != 0) begin
                        mode    = `SEO_MODE_PUMP;
                        pump_on = assert_req;
                    end
                end
                default: begin
                    active_high = 1'b0;
                end
            endcase
        end
    end
endmodule

/* seo_supply_load.sv */
// Load model of the regulator enable inputs on the supply-enable pins
`timescale 1ns/1ps
module seo_supply_load (
    input  wire [11:0] pin_out,
    input  wire [11:0] pin_oe_n,
    output wire [11:0] pin_level
);
    assign pin_level = pin_oe_n | pin_out;
endmodule

/* seo_cfg_chk.sv */
// Checker of the supply-enable configuration bank
`timescale 1ns/1ps
module seo_cfg_chk #(
    parameter NUM_CH = 12
) (
    input wire        core_clk,
    input wire        sys_rst,
    input wire        cfg_wr_en,
    input wire        cfg_rd_en,
    input wire [7:0]  cfg_addr,
    input wire [7:0]  cfg_wdata,
    input wire [11:0] slot_done,
    input wire [7:0]  cfg_rdata_q,
    input wire [11:0] supply_enable_oe_n_q,
    input wire [11:0] charge_pump_on_q,
    input wire [11:0] track_on_q,
    input wire [11:0] cfg_reserved_q,
    input wire [11:0] asserted_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr;
        cfg_wr_en && cfg_addr == 8'h20;
    endsequence
    sequence s_rd;
        !cfg_wr_en && cfg_rd_en && cfg_addr == 8'h20;
    endsequence
    sequence s_unmap;
        cfg_rd_en && (cfg_addr < 8'h1F || cfg_addr > 8'h22);
    endsequence
    wire [11:0] non_drv = charge_pump_on_q | track_on_q | cfg_reserved_q;
    AST_WR_RD: assert property (s_wr ##1 s_rd |=> cfg_rdata_q == $past(cfg_wdata, 2))
        else $error("read-back differs from write");
    AST_RD_D: assert property (cfg_rd_en && cfg_addr == 8'h22 |=> cfg_rdata_q[7:6] == 2'b00)
        else $error("reserved bits read nonzero");
    AST_RD_UNMAP: assert property (s_unmap |=> cfg_rdata_q == 8'h00)
        else $error("unmapped read nonzero");
    AST_TRACK_CH: assert property (track_on_q[11:4] == 8'h00)
        else $error("tracking on channel above four");
    AST_PUMP_CH: assert property (charge_pump_on_q[11:6] == 6'h00)
        else $error("pump on channel above six");
    AST_RSVD_CH: assert property (cfg_reserved_q[11:6] == 6'h00)
        else $error("reserved flag on two-bit channel");
    AST_IDLE: assert property ((non_drv & ~supply_enable_oe_n_q) == 12'h000)
        else $error("pin driven in non-driver mode");
    AST_ASSERT_CAUSE: assert property ((asserted_q & ~$past(slot_done, 2)) == 12'h000)
        else $error("output asserted without slot");
endmodule
bind seo_enable_out_cfg seo_cfg_chk #(.NUM_CH(NUM_CH)) u_chk (.core_clk, .sys_rst,
    .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wdata, .slot_done, .cfg_rdata_q,
    .supply_enable_oe_n_q, .charge_pump_on_q, .track_on_q, .cfg_reserved_q, .asserted_q);

/* seo_tb.sv */
// Testbench of the supply-enable configuration bank
`timescale 1ns/1ps
module tb;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         we = 1'b0;
    reg         re = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [7:0]  wdat = 8'h00;
    reg  [11:0] slot = 12'h000;
    wire [7:0]  rdat;
    wire [11:0] pout, oe_n, pump, trk, rsv, asr, lvl;
    wire [11:0] sm_oe_n, sm_rsv, sm_asr;
    integer     bad_count = 0;
    integer     comparisons = 0;
    integer     i;
    reg  [3:0]  c;
    always #50 clk = ~clk;
    seo_enable_out_cfg #(.NUM_CH(12)) dut (.core_clk(clk), .sys_rst(rst), .cfg_wr_en(we),
        .cfg_rd_en(re), .cfg_addr(addr), .cfg_wdata(wdat), .slot_done(slot),
        .cfg_rdata_q(rdat), .supply_enable_outputs_all_q(pout), .supply_enable_oe_n_q(oe_n),
        .charge_pump_on_q(pump), .track_on_q(trk), .cfg_reserved_q(rsv), .asserted_q(asr));
    seo_enable_out_cfg #(.NUM_CH(8)) dut_small (.core_clk(clk), .sys_rst(rst), .cfg_wr_en(we),
        .cfg_rd_en(re), .cfg_addr(addr), .cfg_wdata(wdat), .slot_done(slot),
        .cfg_rdata_q(), .supply_enable_outputs_all_q(), .supply_enable_oe_n_q(sm_oe_n),
        .charge_pump_on_q(), .track_on_q(), .cfg_reserved_q(sm_rsv), .asserted_q(sm_asr));
    seo_supply_load load (.pin_out(pout), .pin_oe_n(oe_n), .pin_level(lvl));
    task chk(input [11:0] got, input [11:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            addr = a;
            wdat = d;
            we = 1'b1;
            tick;
            we = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            addr = a;
            re = 1'b1;
            tick;
            re = 1'b0;
            tick;
            chk({4'h0, rdat}, {4'h0, e});
        end
    endtask
    // Channel n code in k[3n-1:3n-3]
    task cfg(input [35:0] k);
        begin
            wr(8'h1F, {k[7:6], k[5:3], k[2:0]});
            tick;
            wr(8'h20, {k[15], k[14:12], k[11:9], k[8]});
            tick;
            wr(8'h21, {k[25:24], k[22:21], k[19:18], k[17:16]});
            tick;
            wr(8'h22, {2'b00, k[34:33], k[31:30], k[28:27]});
            tick;
            tick;
        end
    endtask
    task results;
        begin
            if (bad_count == 0 && comparisons > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 8'h1E; i <= 8'h23; i = i + 1)
            rd(i[7:0], 8'h00);
        wr(8'h23, 8'hFF);
        rd(8'h23, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h1F + i[7:0], 8'hA5 + i[7:0]);
            rd(8'h1F + i[7:0], (8'hA5 + i[7:0]) & ((i == 3) ? 8'h3F : 8'hFF));
        end
        for (c = 0; c < 4; c = c + 1) begin
            cfg({12{c[2:0]}});
            slot = 12'h000;
            tick;
            tick;
            chk(lvl, {12{~c[0]}});
            chk(oe_n, c[1] ? 12'h000 : {12{~c[0]}});
            chk(sm_oe_n, {4'hF, (c[1] ? 8'h00 : {8{~c[0]}})});
            slot = 12'hFFF;
            tick;
            chk(asr, 12'h000);
            tick;
            chk(asr, 12'hFFF);
            chk(sm_asr, 12'h0FF);
            chk(lvl, {12{c[0]}});
            chk(oe_n, c[1] ? 12'h000 : {12{c[0]}});
            chk(pout, c[1] ? {12{c[0]}} : 12'h000);
            chk(sm_oe_n, {4'hF, (c[1] ? 8'h00 : {8{c[0]}})});
        end
        cfg({6{3'd0, 3'd3}});
        chk(lvl, 12'h555);
        for (c = 4; c < 8; c = c + 1) begin
            cfg({{6{3'd0}}, {6{c[2:0]}}});
            chk(trk, (c == 4) ? 12'h00F : 12'h000);
            chk(pump, (c == 5) ? 12'h03F : 12'h000);
            chk(rsv, (c == 4) ? 12'h030 : ((c > 5) ? 12'h03F : 12'h000));
            chk(sm_rsv, (c == 4) ? 12'h030 : ((c > 5) ? 12'h03F : 12'h000));
            chk(oe_n, 12'h03F);
        end
        rst = 1'b1;
        tick;
        chk(oe_n, 12'hFFF);
        chk(asr, 12'h000);
        rst = 1'b0;
        rd(8'h20, 8'h00);
        results;
    end
endmodule
